// file: logic/spi_port_pkg.sv
// Shared constants and types for the serial peripheral port
package spi_port_pkg;
    localparam int unsigned CLK_PERIOD_NS      = 20;
    localparam int unsigned CHAR_BITS          = 8;
    // Least slave-mode serial clock period, in system clock periods
    localparam int unsigned SLAVE_MIN_SCK_CLKS = 8;
    localparam int unsigned SLAVE_MIN_SCK_NS   = SLAVE_MIN_SCK_CLKS * CLK_PERIOD_NS;
    localparam int unsigned BAUD_W             = 16;

    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_DATA    = 8'h08;
    localparam logic [7:0] OFS_BAUD_HI = 8'h0c;
    localparam logic [7:0] OFS_BAUD_LO = 8'h10;

    localparam int unsigned CTRL_EN_BIT     = 0;
    localparam int unsigned CTRL_MASTER_BIT = 1;
    localparam int unsigned CTRL_POL_BIT    = 2;
    localparam int unsigned ST_BUSY_BIT     = 0;
    localparam int unsigned ST_RXFULL_BIT   = 1;
    localparam int unsigned ST_TXRDY_BIT    = 2;

    localparam logic [7:0] BAUD_HI_RST = 8'hff;
    localparam logic [7:0] BAUD_LO_RST = 8'hff;

    typedef enum logic [1:0] {
        XF_IDLE  = 2'b01,
        XF_SHIFT = 2'b10
    } xfer_state_t;
endpackage

// file: logic/brg_if.sv
// Link between the port core and its baud rate generator
`timescale 1ns/1ps
interface brg_if;
    logic [15:0] baud_reload_value;
    logic        run;
    logic        tick;
    modport gen  (input baud_reload_value, input run, output tick);
    modport user (output baud_reload_value, output run, input tick);
endinterface

// file: logic/baud_gen.sv
// Baud rate generator: one tick every reload-value system clocks
`timescale 1ns/1ps
module baud_gen (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    brg_if.gen        bus
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } bg_state_t;

    bg_state_t r;
    bg_state_t n;

    // Reload of zero behaves as one
    always_comb begin
        n      = r;
        n.tick = 1'b0;
        if (!bus.run) begin
            n.cnt = bus.baud_reload_value;
        end else if (r.cnt <= 16'h0001) begin
            n.cnt  = bus.baud_reload_value;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt - 16'h0001;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign bus.tick = r.tick;

    property p_tick_spacing;
        @(posedge clock_i) disable iff (!rst_n_i)
        (bus.run && r.tick && bus.baud_reload_value == 16'h0003 &&
         $stable(bus.baud_reload_value)) ##1 bus.run [*2]
            |-> !r.tick && !$past(r.tick) ##1 r.tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("baud tick spacing wrong");
endmodule

// file: logic/spi_port.sv
// Serial peripheral port, master or slave, with an APB register file
//
// Functional notes
// - Eight-bit shift registers form one ring
// - One buffer; load refused while busy/unread
// - Data-in line input as master, output slave
// - Most significant bit travels first
// - Unselected slave floats its data output
// - Disabled port floats both data pins
// - Data-out line output as master, input slave
// - Master clock from baud generator, driven out
// - Slave shifts on the master's clock
// - Slave ignores clock unless selected
// - Phase zero format, polarity picks waveform
// - Sixteen-bit reload from high, low bytes
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module spi_port #(
    parameter int unsigned DATA_W = spi_port_pkg::CHAR_BITS
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe_o,
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe_o,
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    input  wire logic        ss_n_i
);
    localparam int unsigned CW = $clog2(2 * DATA_W) + 1;
    localparam logic [CW-1:0] LAST_HALF = CW'(2 * DATA_W - 1);
    localparam logic [CW-1:0] LAST_BIT  = CW'(DATA_W - 1);
    localparam logic [CW-1:0] CNT_ONE   = CW'(1);

    if (DATA_W < 2 || DATA_W > 16) begin : g_bad_width
        $error("DATA_W must lie between 2 and 16");
    end

    typedef struct packed {
        spi_port_pkg::xfer_state_t st;
        logic [DATA_W-1:0]         shreg;
        logic                      samp;
        logic [CW-1:0]             cnt;
        logic                      rx_full;
        logic                      en;
        logic                      master;
        logic                      sck_idle_polarity;
        logic [7:0]                baud_hi;
        logic [7:0]                baud_lo;
        logic                      sck;
        logic [1:0]                sck_sy;
        logic [1:0]                mosi_sy;
        logic [1:0]                miso_sy;
        logic [1:0]                ssn_sy;
        logic                      sck_d;
        logic [31:0]               prdata;
    } state_t;

    state_t r;
    state_t n;

    brg_if bif ();

    baud_gen u_baud (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .bus     (bif.gen)
    );

    function automatic logic is_mapped(input logic [7:0] a);
        return a == spi_port_pkg::OFS_CTRL || a == spi_port_pkg::OFS_STATUS ||
               a == spi_port_pkg::OFS_DATA || a == spi_port_pkg::OFS_BAUD_HI ||
               a == spi_port_pkg::OFS_BAUD_LO;
    endfunction

    logic busy;
    logic selected;
    logic wr_ok;
    logic setup;
    logic acc;
    logic sck_chg;
    logic lead;
    logic trail;
    logic m_tick;

    assign busy     = r.st == spi_port_pkg::XF_SHIFT;
    assign selected = r.en && !r.master && !r.ssn_sy[1];
    assign wr_ok    = !busy && !r.rx_full;
    assign setup    = psel_i && !penable_i;
    assign acc      = psel_i && penable_i;
    assign sck_chg  = r.sck_sy[1] != r.sck_d;
    // Leading edge leaves the idle level, trailing edge returns to it
    assign lead     = sck_chg && r.sck_sy[1] != r.sck_idle_polarity;
    assign trail    = sck_chg && r.sck_sy[1] == r.sck_idle_polarity;
    assign m_tick   = r.en && r.master && busy && bif.tick;

    assign bif.baud_reload_value = {r.baud_hi, r.baud_lo};
    assign bif.run               = r.en && r.master && busy;

    always_comb begin
        n         = r;
        n.sck_sy  = {r.sck_sy[0], sck_i};
        n.mosi_sy = {r.mosi_sy[0], mosi_i};
        n.miso_sy = {r.miso_sy[0], miso_i};
        n.ssn_sy  = {r.ssn_sy[0], ss_n_i};
        n.sck_d   = r.sck_sy[1];

        // Read data prepared in the setup cycle, ready at the access edge
        if (setup && !pwrite_i) begin
            n.prdata = 32'h0000_0000;
            case (paddr_i)
                spi_port_pkg::OFS_CTRL: begin
                    n.prdata[spi_port_pkg::CTRL_EN_BIT]     = r.en;
                    n.prdata[spi_port_pkg::CTRL_MASTER_BIT] = r.master;
                    n.prdata[spi_port_pkg::CTRL_POL_BIT]    = r.sck_idle_polarity;
                end
                spi_port_pkg::OFS_STATUS: begin
                    n.prdata[spi_port_pkg::ST_BUSY_BIT]   = busy;
                    n.prdata[spi_port_pkg::ST_RXFULL_BIT] = r.rx_full;
                    n.prdata[spi_port_pkg::ST_TXRDY_BIT]  = wr_ok;
                end
                spi_port_pkg::OFS_DATA:    n.prdata[DATA_W-1:0] = r.shreg;
                spi_port_pkg::OFS_BAUD_HI: n.prdata[7:0] = r.baud_hi;
                spi_port_pkg::OFS_BAUD_LO: n.prdata[7:0] = r.baud_lo;
                default:                   n.prdata = 32'h0000_0000;
            endcase
        end

        if (acc && pwrite_i) begin
            case (paddr_i)
                spi_port_pkg::OFS_CTRL: begin
                    n.en                = pwdata_i[spi_port_pkg::CTRL_EN_BIT];
                    n.master            = pwdata_i[spi_port_pkg::CTRL_MASTER_BIT];
                    n.sck_idle_polarity = pwdata_i[spi_port_pkg::CTRL_POL_BIT];
                end
                spi_port_pkg::OFS_DATA: begin
                    // Single buffer: no load over a live or unread byte
                    if (wr_ok) begin
                        n.shreg = pwdata_i[DATA_W-1:0];
                        n.cnt   = '0;
                        if (r.en && r.master) begin
                            n.st = spi_port_pkg::XF_SHIFT;
                        end
                    end
                end
                spi_port_pkg::OFS_BAUD_HI: n.baud_hi = pwdata_i[7:0];
                spi_port_pkg::OFS_BAUD_LO: n.baud_lo = pwdata_i[7:0];
                default: ;
            endcase
        end else if (acc && paddr_i == spi_port_pkg::OFS_DATA) begin
            n.rx_full = 1'b0;
        end

        // Master: even half periods sample, odd ones shift
        if (m_tick) begin
            n.sck = !r.sck;
            n.cnt = r.cnt + CNT_ONE;
            if (!r.cnt[0]) begin
                n.samp = r.miso_sy[1];
            end else begin
                n.shreg = {r.shreg[DATA_W-2:0], r.samp};
            end
            if (r.cnt == LAST_HALF) begin
                n.st      = spi_port_pkg::XF_IDLE;
                n.cnt     = '0;
                n.rx_full = 1'b1;
            end
        end

        // Slave: synchronised clock edges, only while selected
        if (selected) begin
            if (lead) begin
                n.samp = r.mosi_sy[1];
                n.st   = spi_port_pkg::XF_SHIFT;
            end else if (trail && busy) begin
                n.shreg = {r.shreg[DATA_W-2:0], r.samp};
                n.cnt   = r.cnt + CNT_ONE;
                if (r.cnt == LAST_BIT) begin
                    n.st      = spi_port_pkg::XF_IDLE;
                    n.cnt     = '0;
                    n.rx_full = 1'b1;
                end
            end
        end else if (!r.master) begin
            // Deselect mid-byte drops the partial byte
            n.st  = spi_port_pkg::XF_IDLE;
            n.cnt = '0;
        end

        if (!n.en || n.master != r.master) begin
            n.st  = spi_port_pkg::XF_IDLE;
            n.cnt = '0;
        end
        if (n.st == spi_port_pkg::XF_IDLE) begin
            n.sck = n.sck_idle_polarity;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r         <= '0;
            r.st      <= spi_port_pkg::XF_IDLE;
            r.baud_hi <= spi_port_pkg::BAUD_HI_RST;
            r.baud_lo <= spi_port_pkg::BAUD_LO_RST;
            r.ssn_sy  <= 2'b11;
        end else begin
            r <= n;
        end
    end

    assign prdata_o  = r.prdata;
    assign pready_o  = 1'b1;
    assign pslverr_o = acc && (!is_mapped(paddr_i) ||
                       (pwrite_i && paddr_i == spi_port_pkg::OFS_DATA && !wr_ok));
    assign sck_o     = r.sck;
    assign sck_oe_o  = r.en && r.master;
    assign mosi_o    = r.shreg[DATA_W-1];
    assign mosi_oe_o = r.en && r.master;
    assign miso_o    = r.shreg[DATA_W-1];
    // Select is seen two clocks late; the slow slave clock covers it
    assign miso_oe_o = selected;

    property p_miso_dir;
        @(posedge clock_i) disable iff (!rst_n_i)
        r.master |-> !miso_oe_o;
    endproperty
    a_miso_dir: assert property (p_miso_dir) else $error("data-in driven as master");

    property p_miso_unsel;
        @(posedge clock_i) disable iff (!rst_n_i)
        (r.en && !r.master && $past(ss_n_i, 3) && $past(ss_n_i, 2)) |-> !miso_oe_o;
    endproperty
    a_miso_unsel: assert property (p_miso_unsel) else $error("unselected slave drives");

    property p_off_float;
        @(posedge clock_i) disable iff (!rst_n_i)
        !r.en |-> !miso_oe_o && !mosi_oe_o && !sck_oe_o;
    endproperty
    a_off_float: assert property (p_off_float) else $error("disabled port drives pins");

    property p_mosi_dir;
        @(posedge clock_i) disable iff (!rst_n_i)
        (r.en && !r.master) |-> !mosi_oe_o;
    endproperty
    a_mosi_dir: assert property (p_mosi_dir) else $error("data-out driven as slave");

    property p_sck_follows_tick;
        @(posedge clock_i) disable iff (!rst_n_i)
        (m_tick && r.cnt != LAST_HALF &&
         !(acc && pwrite_i && paddr_i == spi_port_pkg::OFS_CTRL))
            |=> sck_o != $past(sck_o) && sck_oe_o;
    endproperty
    a_sck_follows_tick: assert property (p_sck_follows_tick) else $error("clock stuck");

    property p_slave_no_clock_out;
        @(posedge clock_i) disable iff (!rst_n_i)
        !r.master |-> !sck_oe_o;
    endproperty
    a_slave_no_clock_out: assert property (p_slave_no_clock_out) else $error("clock out");

    property p_slave_ignore;
        @(posedge clock_i) disable iff (!rst_n_i)
        (r.en && !r.master && r.ssn_sy[1] && !(acc && pwrite_i)) |=> $stable(r.shreg) && !busy;
    endproperty
    a_slave_ignore: assert property (p_slave_ignore) else $error("idle slave shifted");

    property p_refuse;
        @(posedge clock_i) disable iff (!rst_n_i)
        (acc && pwrite_i && paddr_i == spi_port_pkg::OFS_DATA && busy && !m_tick && !trail)
            |-> pslverr_o ##1 $stable(r.shreg);
    endproperty
    a_refuse: assert property (p_refuse) else $error("load accepted while busy");

    property p_idle_level;
        @(posedge clock_i) disable iff (!rst_n_i)
        (r.st == spi_port_pkg::XF_IDLE && $stable(r.sck_idle_polarity))
            |-> sck_o == r.sck_idle_polarity;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("clock not idle at polarity");

    property p_master_done;
        @(posedge clock_i) disable iff (!rst_n_i)
        (m_tick && r.cnt == LAST_HALF && !(acc && paddr_i == spi_port_pkg::OFS_CTRL))
            |=> !busy && r.rx_full && sck_o == r.sck_idle_polarity;
    endproperty
    a_master_done: assert property (p_master_done) else $error("transfer not ended");

    property p_msb_next;
        @(posedge clock_i) disable iff (!rst_n_i)
        (m_tick && r.cnt[0]) |=> mosi_o == $past(r.shreg[DATA_W-2]);
    endproperty
    a_msb_next: assert property (p_msb_next) else $error("bit order wrong");
endmodule

// file: tb/spi_peer.sv
// Behavioural far-side slave that faces the port when it runs as master
`timescale 1ns/1ps
module spi_peer (
    input  wire logic       sck_i,
    input  wire logic       pol_i,
    input  wire logic       sel_n_i,
    input  wire logic       mosi_i,
    input  wire logic [7:0] load_i,
    output logic            miso_o,
    output logic [7:0]      got_o
);
    logic [7:0] shreg_r;
    logic       bit_r;
    logic       sel_d_r = 1'b1;
    logic       junk_r = 1'b0;

    // One process owns the shift register: select loads, clock edges move bits
    always @(sck_i or sel_n_i) begin
        if (sel_n_i !== sel_d_r) begin
            sel_d_r = sel_n_i;
            if (!sel_n_i) begin
                shreg_r = load_i;
            end
        end else if (!sel_n_i && sck_i !== pol_i) begin
            bit_r = mosi_i;
        end else if (!sel_n_i) begin
            shreg_r = {shreg_r[6:0], bit_r};
            got_o = shreg_r;
        end
    end
    // Released line must not look like valid data
    always #7 junk_r = ~junk_r;
    assign miso_o = sel_n_i ? junk_r : shreg_r[7];
endmodule

// file: tb/tb_top.sv
// Self-checking bench: APB master, serial pin drivers and far-side peer
`timescale 1ns/1ps
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (x)); end end
module tb_top;
    typedef struct packed {
        logic       pol;
        logic [7:0] tx;
        logic [7:0] peer;
    } row_t;
    logic        clock, rst_n, psel, penable, pwrite, tb_sck, tb_mosi, ss_n, peer_sel_n;
    logic        pol, pready, pslverr, e, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic        peer_miso, sck_w, mosi_w, miso_w;
    logic [7:0]  paddr, peer_load, peer_got, r8;
    logic [31:0] pwdata, prdata, q;
    int          errors, checked, cycles, sck_edges;
    time         gap, t_last;
    row_t        rows [4] = '{'{1'b0, 8'ha5, 8'h3c}, '{1'b1, 8'h81, 8'h7e},
                             '{1'b0, 8'hff, 8'h00}, '{1'b1, 8'h00, 8'hff}};

    assign sck_w  = sck_oe ? sck_o : tb_sck;
    assign mosi_w = mosi_oe ? mosi_o : tb_mosi;
    assign miso_w = miso_oe ? miso_o : peer_miso;

    spi_port i_spi_port (
        .clock_i(clock), .rst_n_i(rst_n), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sck_i(sck_w), .sck_o(sck_o),
        .sck_oe_o(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe), .ss_n_i(ss_n));
    spi_peer i_spi_peer (
        .sck_i(sck_w), .pol_i(pol), .sel_n_i(peer_sel_n), .mosi_i(mosi_w),
        .load_i(peer_load), .miso_o(peer_miso), .got_o(peer_got));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(sck_o) if (rst_n) begin
        sck_edges++;
        gap = $time - t_last;
        t_last = $time;
    end

    // Whole run needs under 2000 cycles; ceiling leaves margin
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic slave_xfer(input logic [7:0] b);
        ss_n <= 1'b0;
        repeat (4) @(posedge clock);
        for (int i = 7; i >= 0; i--) begin
            tb_mosi <= b[i];
            repeat (5) @(posedge clock);
            tb_sck <= ~pol;
            r8[i] = miso_w;
            repeat (5) @(posedge clock);
            tb_sck <= pol;
        end
        repeat (5) @(posedge clock);
        `CHK(miso_oe, 1'b1)
        ss_n <= 1'b1;
        tb_mosi <= ~b[0];
    endtask

    initial begin
        rst_n = 1'b0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pol = 0;
        tb_sck = 0; tb_mosi = 0; ss_n = 1; peer_sel_n = 1; peer_load = 0; q = 0; e = 0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        `CHK({sck_oe, mosi_oe, miso_oe}, 3'b000)
        apb(1'b0, spi_port_pkg::OFS_STATUS, 0);
        `CHK(q[2:0], 3'b100)
        apb(1'b0, spi_port_pkg::OFS_BAUD_HI, 0);
        `CHK(q, 32'hff)
        apb(1'b0, 8'h14, 0);
        `CHK({e, q}, {1'b1, 32'h0})
        apb(1'b1, spi_port_pkg::OFS_BAUD_HI, 32'h0);
        apb(1'b1, spi_port_pkg::OFS_BAUD_LO, 32'h3);
        apb(1'b0, spi_port_pkg::OFS_BAUD_LO, 0);
        `CHK(q, 32'h3)
        foreach (rows[k]) begin
            pol = rows[k].pol;
            apb(1'b1, spi_port_pkg::OFS_CTRL, {29'h0, rows[k].pol, 2'b11});
            peer_load <= rows[k].peer;
            peer_sel_n <= 1'b0;
            `CHK({sck_o, sck_oe, mosi_oe, miso_oe}, {rows[k].pol, 3'b110})
            sck_edges = 0;
            apb(1'b1, spi_port_pkg::OFS_DATA, {24'h0, rows[k].tx});
            apb(1'b1, spi_port_pkg::OFS_DATA, 32'h0);
            `CHK(e, 1'b1)
            q = 0;
            repeat (100) if (q[1] !== 1'b1) apb(1'b0, spi_port_pkg::OFS_STATUS, 0);
            `CHK(q[2:0], 3'b010)
            `CHK(peer_got, rows[k].tx)
            `CHK(sck_edges, 16)
            `CHK(gap, 64'd60)
            `CHK(sck_o, rows[k].pol)
            apb(1'b1, spi_port_pkg::OFS_DATA, 32'h0);
            `CHK(e, 1'b1)
            apb(1'b0, spi_port_pkg::OFS_DATA, 0);
            `CHK(q[7:0], rows[k].peer)
            peer_sel_n <= 1'b1;
        end
        pol = 1'b0;
        tb_sck <= 1'b0;
        apb(1'b1, spi_port_pkg::OFS_CTRL, 32'h1);
        for (int i = 0; i < 15; i++) begin
            repeat (5) @(posedge clock);
            tb_sck <= ~tb_sck;
        end
        repeat (5) @(posedge clock);
        tb_sck <= 1'b0;
        `CHK({sck_oe, mosi_oe, miso_oe}, 3'b000)
        apb(1'b0, spi_port_pkg::OFS_STATUS, 0);
        `CHK(q[2:0], 3'b100)
        apb(1'b1, spi_port_pkg::OFS_DATA, 32'hc3);
        slave_xfer(8'h5a);
        `CHK(r8, 8'hc3)
        apb(1'b0, spi_port_pkg::OFS_DATA, 0);
        `CHK(q[7:0], 8'h5a)
        pol = 1'b1;
        tb_sck <= 1'b1;
        apb(1'b1, spi_port_pkg::OFS_CTRL, 32'h5);
        apb(1'b1, spi_port_pkg::OFS_DATA, 32'h3c);
        slave_xfer(8'ha6);
        `CHK(r8, 8'h3c)
        apb(1'b0, spi_port_pkg::OFS_DATA, 0);
        `CHK(q[7:0], 8'ha6)
        apb(1'b1, spi_port_pkg::OFS_CTRL, 32'h2);
        `CHK({sck_oe, mosi_oe, miso_oe}, 3'b000)
        complete_run();
    end
endmodule
